// ===== core/lfc_consts.vh
// Overview of operation
// - Format bit 7 set opens the baud divisor latch; clear keeps it closed.
// - Format bit 6 set holds the transmit output low until software clears it.
// - Format bit 3 set adds a parity bit when sending and checks it when receiving.
// - With parity enabled and not forced, bit 4 clear is odd, set is even.
// - Parity enabled with bit 5 set forces parity: 1 if bit 4 clear, else 0.
// - Bit 5 clear means normal parity; parity enable clear means no parity at all.
// - Bit 2 clear gives exactly one stop bit for every word length.
// - Bit 2 set gives 1.5 stop bits for 5-bit words, 2 otherwise.
// - Bits 1:0 select 5, 6, 7 or 8 data bits for both directions.
`ifndef LFC_CONSTS_VH
`define LFC_CONSTS_VH

// ------------------------------------------------------------------
// Register word offsets within a channel (paddr[3:2])
// ------------------------------------------------------------------
`define OFF_FMT       2'h0
`define OFF_DATA      2'h1
`define OFF_STATUS    2'h2
`define OFF_RXDATA    2'h3
`define CH_SEL_BIT    4
`define ADDR_TOP_BIT  5

// ------------------------------------------------------------------
// Line format register fields
// ------------------------------------------------------------------
`define FMT_DIV_EN    7
`define FMT_BREAK     6
`define FMT_STICK     5
`define FMT_EVEN      4
`define FMT_PAR_EN    3
`define FMT_STOP2     2
`define FMT_WL_HI     1
`define FMT_WL_LO     0

// ------------------------------------------------------------------
// Status register fields
// ------------------------------------------------------------------
`define ST_TX_BUSY    0
`define ST_RX_VALID   1
`define ST_PAR_ERR    2
`define ST_FRM_ERR    3

// ------------------------------------------------------------------
// Reset values and timing
// ------------------------------------------------------------------
`define FMT_RST       8'h00
`define DIV_RST       16'h0008
`define WL_MASK_BASE  8'hE0
`define HALVES_BIT    3'h2
`define HALVES_STOP15 3'h3
`define HALVES_STOP2  3'h4

`endif

// ===== core/uart_char_tx.v
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Character transmitter: frames one character per start request
// ------------------------------------------------------------------
`include "lfc_consts.vh"
module uart_char_tx (
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // Character request
    input  wire        start,
    input  wire [7:0]  data,
    input  wire [5:0]  fmt,
    input  wire [15:0] half_div,
    // Line side
    output reg         busy,
    output reg         line
);
    localparam S_IDLE  = 5'b00001;
    localparam S_START = 5'b00010;
    localparam S_DATA  = 5'b00100;
    localparam S_PAR   = 5'b01000;
    localparam S_STOP  = 5'b10000;

    reg  [4:0]  st_q;
    reg  [15:0] cnt_q;
    reg  [2:0]  hc_q;
    reg  [2:0]  bitn_q;
    reg  [7:0]  sh_q;
    reg  [5:0]  fmt_q;
    reg         par_q;
    wire        tick     = (cnt_q == 16'h0000);
    wire        bit_end  = tick && (hc_q == 3'h1);
    wire [7:0]  wl_shift = `WL_MASK_BASE << fmt[`FMT_WL_HI:`FMT_WL_LO];
    wire [7:0]  masked   = data & ~wl_shift;
    wire [15:0] reload   = (half_div == 16'h0000) ? 16'h0000 : half_div - 16'h0001;
    wire [2:0]  last_bit = {1'b1, fmt_q[`FMT_WL_HI:`FMT_WL_LO]};
    wire        five     = (fmt_q[`FMT_WL_HI:`FMT_WL_LO] == 2'b00);
    wire [2:0]  stop_hc  = !fmt_q[`FMT_STOP2] ? `HALVES_BIT :
                           (five ? `HALVES_STOP15 : `HALVES_STOP2);
    wire        par_bit  = fmt[`FMT_STICK] ? ~fmt[`FMT_EVEN] :
                           (fmt[`FMT_EVEN] ? ^masked : ~^masked);

    // Frame sequencer, counted in half bit times
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q   <= S_IDLE;
            cnt_q  <= 16'h0000;
            hc_q   <= 3'h0;
            bitn_q <= 3'h0;
            sh_q   <= 8'h00;
            fmt_q  <= 6'h00;
            par_q  <= 1'b0;
            busy   <= 1'b0;
            line   <= 1'b1;
        end else begin
            cnt_q <= tick ? reload : cnt_q - 16'h0001;
            if (tick && hc_q != 3'h0)
                hc_q <= hc_q - 3'h1;
            case (st_q)
                S_IDLE: begin
                    line <= 1'b1;
                    if (start) begin
                        fmt_q  <= fmt;
                        sh_q   <= masked;
                        par_q  <= par_bit;
                        cnt_q  <= reload;
                        hc_q   <= `HALVES_BIT;
                        busy   <= 1'b1;
                        line   <= 1'b0;
                        st_q   <= S_START;
                    end
                end
                S_START: begin
                    if (bit_end) begin
                        line   <= sh_q[0];
                        sh_q   <= {1'b0, sh_q[7:1]};
                        bitn_q <= 3'h0;
                        hc_q   <= `HALVES_BIT;
                        st_q   <= S_DATA;
                    end
                end
                S_DATA: begin
                    if (bit_end) begin
                        hc_q   <= `HALVES_BIT;
                        bitn_q <= bitn_q + 3'h1;
                        if (bitn_q == last_bit) begin
                            if (fmt_q[`FMT_PAR_EN]) begin
                                line <= par_q;
                                st_q <= S_PAR;
                            end else begin
                                line <= 1'b1;
                                hc_q <= stop_hc;
                                st_q <= S_STOP;
                            end
                        end else begin
                            line <= sh_q[0];
                            sh_q <= {1'b0, sh_q[7:1]};
                        end
                    end
                end
                S_PAR: begin
                    if (bit_end) begin
                        line <= 1'b1;
                        hc_q <= stop_hc;
                        st_q <= S_STOP;
                    end
                end
                S_STOP: begin
                    if (bit_end) begin
                        busy <= 1'b0;
                        st_q <= S_IDLE;
                    end
                end
                default: begin
                    st_q <= S_IDLE;
                    busy <= 1'b0;
                    line <= 1'b1;
                end
            endcase
        end
    end
endmodule // uart_char_tx

// ===== core/uart_line_format_control.v
`timescale 1ns/1ps
`include "lfc_consts.vh"
module uart_line_format_control #(
    parameter NCH = 2
) (
    // APB clock and reset
    input  wire             pclk,
    input  wire             presetn,
    // APB slave
    input  wire             psel,
    input  wire             penable,
    input  wire             pwrite,
    input  wire [31:0]      paddr,
    input  wire [31:0]      pwdata,
    output reg  [31:0]      prdata,
    output reg              pready,
    output reg              pslverr,
    // Serial lines
    output reg  [NCH-1:0]   txd,
    input  wire [NCH-1:0]   rxd
);
    localparam R_IDLE  = 5'b00001;
    localparam R_START = 5'b00010;
    localparam R_DATA  = 5'b00100;
    localparam R_PAR   = 5'b01000;
    localparam R_STOP  = 5'b10000;

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    wire        acc      = psel && penable;
    wire        done     = acc && pready;
    wire [1:0]  woff     = paddr[3:2];
    wire        mapped   = (paddr[31:`ADDR_TOP_BIT] == 27'h0) && (paddr[1:0] == 2'b00)
                           && (paddr[`CH_SEL_BIT] < NCH);
    wire        ch_sel   = paddr[`CH_SEL_BIT];

    wire [8*NCH-1:0]  fmt_flat;
    wire [16*NCH-1:0] div_flat;
    wire [8*NCH-1:0]  rxd_flat;
    wire [4*NCH-1:0]  st_flat;
    wire [NCH-1:0]    tx_line;

    // Read data selection for the addressed channel
    reg  [31:0] rd_d;
    reg  [7:0]  sel_fmt;
    always @* begin
        sel_fmt = fmt_flat[8*ch_sel +: 8];
        rd_d    = 32'h0000_0000;
        case (woff)
            `OFF_FMT:    rd_d = {24'h00_0000, sel_fmt};
            `OFF_DATA:   rd_d = sel_fmt[`FMT_DIV_EN] ?
                                {16'h0000, div_flat[16*ch_sel +: 16]} : 32'h0000_0000;
            `OFF_STATUS: rd_d = {28'h000_0000, st_flat[4*ch_sel +: 4]};
            `OFF_RXDATA: rd_d = {24'h00_0000, rxd_flat[8*ch_sel +: 8]};
            default:     rd_d = 32'h0000_0000;
        endcase
    end

    // Bus answer: one wait state, data and error registered
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= acc && !pready;
            if (acc && !pready) begin
                prdata  <= (mapped && !pwrite) ? rd_d : 32'h0000_0000;
                pslverr <= !mapped;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Per-channel format, transmitter and receiver
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : chan
            reg  [7:0]  fmt_q;
            reg  [15:0] div_q;
            reg         go_q;
            reg  [7:0]  txb_q;
            wire        tx_busy;
            wire        hit   = done && mapped && (ch_sel == g);
            wire        wr    = hit && pwrite;
            wire        rdrx  = hit && !pwrite && (woff == `OFF_RXDATA);

            // Software view of the channel: format, divisor, transmit data
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    fmt_q <= `FMT_RST;
                    div_q <= `DIV_RST;
                    go_q  <= 1'b0;
                    txb_q <= 8'h00;
                end else begin
                    go_q <= 1'b0;
                    if (wr && woff == `OFF_FMT)
                        fmt_q <= pwdata[7:0];
                    if (wr && woff == `OFF_DATA) begin
                        if (fmt_q[`FMT_DIV_EN])
                            div_q <= pwdata[15:0];
                        else if (!tx_busy && !go_q) begin
                            txb_q <= pwdata[7:0];
                            go_q  <= 1'b1;
                        end
                    end
                end
            end

            uart_char_tx u_tx (
                .pclk     (pclk),
                .presetn  (presetn),
                .start    (go_q),
                .data     (txb_q),
                .fmt      (fmt_q[5:0]),
                .half_div (div_q),
                .busy     (tx_busy),
                .line     (tx_line[g])
            );

            // Receiver, sampling at mid-bit in half bit time steps
            reg  [4:0]  rs_q;
            reg  [15:0] rc_q;
            reg  [2:0]  rh_q;
            reg  [2:0]  rb_q;
            reg  [7:0]  rsh_q;
            reg  [5:0]  rf_q;
            reg         rpar_q;
            reg         rprev_q;
            reg  [7:0]  rdat_q;
            reg         rval_q;
            reg         perr_q;
            reg         ferr_q;
            wire        rtick = (rc_q == 16'h0000);
            wire        samp  = rtick && (rh_q == 3'h1);
            wire [15:0] rrel  = (div_q == 16'h0000) ? 16'h0000 : div_q - 16'h0001;
            wire [7:0]  rjust = rsh_q >> (2'd3 - rf_q[`FMT_WL_HI:`FMT_WL_LO]);
            wire        rexp  = rf_q[`FMT_STICK] ? ~rf_q[`FMT_EVEN] :
                                (rf_q[`FMT_EVEN] ? ^rjust : ~^rjust);
            wire        stopb = rs_q == R_STOP && samp;

            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    rs_q    <= R_IDLE;
                    rc_q    <= 16'h0000;
                    rh_q    <= 3'h0;
                    rb_q    <= 3'h0;
                    rsh_q   <= 8'h00;
                    rf_q    <= 6'h00;
                    rpar_q  <= 1'b0;
                    rprev_q <= 1'b1;
                end else begin
                    rprev_q <= rxd[g];
                    rc_q    <= rtick ? rrel : rc_q - 16'h0001;
                    if (rtick && rh_q != 3'h0)
                        rh_q <= rh_q - 3'h1;
                    case (rs_q)
                        R_IDLE: begin
                            if (rprev_q && !rxd[g]) begin
                                rf_q  <= fmt_q[5:0];
                                rc_q  <= rrel;
                                rh_q  <= 3'h1;
                                rs_q  <= R_START;
                            end
                        end
                        R_START: begin
                            if (samp) begin
                                rb_q <= 3'h0;
                                rh_q <= `HALVES_BIT;
                                rs_q <= rxd[g] ? R_IDLE : R_DATA;
                            end
                        end
                        R_DATA: begin
                            if (samp) begin
                                rsh_q <= {rxd[g], rsh_q[7:1]};
                                rb_q  <= rb_q + 3'h1;
                                rh_q  <= `HALVES_BIT;
                                if (rb_q == {1'b1, rf_q[`FMT_WL_HI:`FMT_WL_LO]})
                                    rs_q <= rf_q[`FMT_PAR_EN] ? R_PAR : R_STOP;
                            end
                        end
                        R_PAR: begin
                            if (samp) begin
                                rpar_q <= rxd[g];
                                rh_q   <= `HALVES_BIT;
                                rs_q   <= R_STOP;
                            end
                        end
                        R_STOP: begin
                            if (samp)
                                rs_q <= R_IDLE;
                        end
                        default: rs_q <= R_IDLE;
                    endcase
                end
            end

            // Received character and flags; a new character wins over the read clear
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    rdat_q <= 8'h00;
                    rval_q <= 1'b0;
                    perr_q <= 1'b0;
                    ferr_q <= 1'b0;
                end else if (stopb) begin
                    rdat_q <= rjust;
                    rval_q <= 1'b1;
                    perr_q <= rf_q[`FMT_PAR_EN] && (rpar_q != rexp);
                    ferr_q <= !rxd[g];
                end else if (rdrx) begin
                    rval_q <= 1'b0;
                    perr_q <= 1'b0;
                    ferr_q <= 1'b0;
                end
            end

            // Line output with break override
            always @(posedge pclk or negedge presetn) begin
                if (!presetn)
                    txd[g] <= 1'b1;
                else
                    txd[g] <= tx_line[g] && !fmt_q[`FMT_BREAK];
            end

            assign fmt_flat[8*g +: 8]   = fmt_q;
            assign div_flat[16*g +: 16] = div_q;
            assign rxd_flat[8*g +: 8]   = rdat_q;
            assign st_flat[4*g +: 4]    = {ferr_q, perr_q, rval_q, tx_busy || go_q};
        end
    endgenerate
endmodule // uart_line_format_control

// ===== sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    localparam NCH = 2;
    localparam BT  = 16;
    reg         pclk, presetn, psel, penable, pwrite, ch, err, ok, p, bad;
    reg  [31:0] paddr, pwdata, rd, r;
    reg  [7:0]  fmt, d, dr;
    wire [31:0] prdata;
    wire        pready, pslverr, peer_tx;
    wire [1:0]  txd, rxd;
    integer     errors = 0, n_tests = 0, seed = 99, i, k, t0, t;

    assign rxd = ch ? {peer_tx, 1'b1} : {1'b1, peer_tx};

    uart_line_format_control #(.NCH(NCH)) i_uart_line_format_control (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .txd(txd), .rxd(rxd));
    uart_peer i_uart_peer (.pclk(pclk), .line_in(txd[ch]), .line_out(peer_tx));

    task chk(input [31:0] seen, input [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    task end_sim;
        begin
            if (errors == 0 && n_tests > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask

    // One APB transfer; waits for pready under a bound
    task apb(input w, input [31:0] a, input [31:0] wd);
        begin
            @(posedge pclk);
            {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, wd};
            @(posedge pclk);
            penable <= 1'b1;
            k = 0;
            @(posedge pclk);
            while (pready !== 1'b1 && k < 20) begin
                @(posedge pclk);
                k = k + 1;
            end
            if (pready !== 1'b1) begin
                chk(0, 1);
                end_sim;
            end else begin
                rd = prdata;
                err = pslverr;
                {psel, penable} <= 2'b00;
            end
        end
    endtask

    task rdchk(input [31:0] a, input [31:0] exp);
        begin
            apb(1'b0, a, 32'h0);
            chk(rd, exp);
        end
    endtask

    function [7:0] wmask(input [7:0] f);
        wmask = 8'hFF >> (2'd3 - f[1:0]);
    endfunction

    function exp_par(input [7:0] f, input [7:0] v);
        exp_par = f[5] ? ~f[4] : (f[4] ? ^(v & wmask(f)) : ~^(v & wmask(f)));
    endfunction

    function integer flen(input [7:0] f);
        flen = BT * (6 + f[1:0] + f[3]) + (!f[2] ? BT : (f[1:0] == 2'b00 ? BT * 3 / 2 : 2 * BT));
    endfunction

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, ch} = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values, closed divisor and a refused address
        rdchk(32'h0, 32'h0);
        rdchk(32'h10, 32'h0);
        rdchk(32'h4, 32'h0);
        apb(1'b0, 32'h3, 32'h0);
        chk(err, 1);
        // Divisor opened, written, read back, closed
        apb(1'b1, 32'h0, 32'h80);
        apb(1'b1, 32'h4, 32'h8);
        rdchk(32'h4, 32'h8);
        apb(1'b1, 32'h0, 32'h0);
        // Break for channel 1 only, then released
        apb(1'b1, 32'h10, 32'h40);
        repeat (3) @(posedge pclk);
        chk(txd, 2'b01);
        apb(1'b1, 32'h10, 32'h0);
        repeat (3) @(posedge pclk);
        chk(txd, 2'b11);
        // Corner formats first, then random ones, across both channels
        for (i = 0; i < 28; i = i + 1) begin
            r = $random(seed);
            fmt = i < 4 ? {5'h01, i[1:0]} : (i < 8 ? {2'b00, i[1:0], 4'h8} : {2'b00, r[13:8]});
            d = r[23:16];
            bad = r[30];
            ch <= r[0];
            apb(1'b1, {27'h0, r[0], 4'h0}, {24'h0, fmt});
            apb(1'b1, {27'h0, ch, 4'h4}, {24'h0, d});
            i_uart_peer.recv(fmt[1:0] + 5, fmt[3], BT, dr, p, t0, ok);
            chk(ok, 1);
            if (ok !== 1'b1)
                end_sim;
            chk(dr, d & wmask(fmt));
            if (fmt[3])
                chk(p, exp_par(fmt, d));
            rd = 32'h1;
            k = 0;
            while (rd[0] !== 1'b0 && k < 40) begin
                apb(1'b0, {27'h0, ch, 4'h8}, 32'h0);
                k = k + 1;
            end
            if (rd[0] !== 1'b0) begin
                chk(1, 0);
                end_sim;
            end
            t = i_uart_peer.cyc - t0;
            chk((t >= flen(fmt) - 2) && (t <= flen(fmt) + 6), 1);
            i_uart_peer.send(d, fmt[1:0] + 5, fmt[3] ? exp_par(fmt, d) ^ bad : -1, BT);
            rdchk({27'h0, ch, 4'h8}, {29'h0, fmt[3] & bad, 2'b10});
            rdchk({27'h0, ch, 4'hC}, {24'h0, d & wmask(fmt)});
        end
        end_sim;
    end
endmodule // tb_top

bind uart_line_format_control uart_lfc_chk #(.NCH(NCH)) i_uart_lfc_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .txd(txd), .rxd(rxd));

// ===== sim/uart_lfc_chk.sv
`timescale 1ns/1ps
module uart_lfc_chk #(
    parameter NCH = 2
) (
    // Clock and reset
    input wire           pclk,
    input wire           presetn,
    // APB slave
    input wire           psel,
    input wire           penable,
    input wire           pwrite,
    input wire [31:0]    paddr,
    input wire [31:0]    pwdata,
    input wire [31:0]    prdata,
    input wire           pready,
    input wire           pslverr,
    // Serial lines
    input wire [NCH-1:0] txd,
    input wire [NCH-1:0] rxd
);
    reg  [7:0] fmt_q [0:1];
    wire       wr_fmt = pready && pwrite && !pslverr && (paddr[3:0] == 4'h0);
    wire       rd_ok  = pready && !pwrite && !pslverr;

    // Shadow of each channel's format register
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fmt_q[0] <= 8'h00;
            fmt_q[1] <= 8'h00;
        end else if (wr_fmt) begin
            fmt_q[paddr[4]] <= pwdata[7:0];
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Bus answer timing and refusals
    a_ready_wait: assert property (psel && !penable |-> ##2 pready)
        else $error("pready not two cycles after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_misalign_err: assert property (psel && !penable && paddr[1:0] != 2'b00 |-> ##2 pslverr)
        else $error("misaligned access not refused");
    a_err_reads_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read not zero");
    // Format registers, divisor gate and break
    a_fmt_readback: assert property (rd_ok && paddr[3:0] == 4'h0
        |-> prdata == {24'h0, fmt_q[paddr[4]]})
        else $error("format read back wrong");
    a_div_closed: assert property (rd_ok && paddr[3:0] == 4'h4
        && !fmt_q[paddr[4]][7] |-> prdata == 32'h0)
        else $error("divisor visible while latch closed");
    a_break_low0: assert property (fmt_q[0][6] && $past(fmt_q[0][6]) |-> !txd[0])
        else $error("channel 0 break not low");
    a_break_low1: assert property (fmt_q[1][6] && $past(fmt_q[1][6]) |-> !txd[1])
        else $error("channel 1 break not low");
    a_reset_idle: assert property ($rose(presetn) |-> txd == {NCH{1'b1}} && !pready)
        else $error("outputs not idle after reset");

    // Main scenarios
    c_fmt_write: cover property (wr_fmt);
    c_refused: cover property (pready && pslverr);
    c_break: cover property (fmt_q[1][6] && !txd[1]);
endmodule // uart_lfc_chk

// ===== sim/uart_peer.sv
`timescale 1ns/1ps
module uart_peer (
    // Clock
    input wire pclk,
    // Serial lines
    input wire line_in,
    output reg line_out
);
    integer cyc = 0;

    // Free cycle count for frame timing
    always @(posedge pclk) cyc <= cyc + 1;

    initial line_out = 1'b1;

    // Send one character; pb below zero means no parity bit
    task send(input [7:0] d, input integer wl, input integer pb, input integer bt);
        integer i;
        begin
            @(posedge pclk) line_out <= 1'b0;
            repeat (bt) @(posedge pclk);
            for (i = 0; i < wl; i = i + 1) begin
                line_out <= d[i];
                repeat (bt) @(posedge pclk);
            end
            if (pb >= 0) begin
                line_out <= pb[0];
                repeat (bt) @(posedge pclk);
            end
            line_out <= 1'b1;
            repeat (2 * bt) @(posedge pclk);
        end
    endtask

    // Receive one character, sampling mid-bit
    task recv(input integer wl, input integer pe, input integer bt,
              output [7:0] d, output p, output integer t0, output ok);
        integer i;
        begin
            i = 0;
            while (line_in !== 1'b0 && i < 2000) begin
                @(posedge pclk);
                i = i + 1;
            end
            ok = (i < 2000);
            t0 = cyc;
            d = 8'h00;
            p = 1'b0;
            repeat (bt / 2) @(posedge pclk);
            for (i = 0; i < wl; i = i + 1) begin
                repeat (bt) @(posedge pclk);
                d[i] = line_in;
            end
            if (pe != 0) begin
                repeat (bt) @(posedge pclk);
                p = line_in;
            end
        end
    endtask
endmodule // uart_peer
